// ===== rtl/asu_pkg.sv
package asu_pkg;
   // Clock and timing
   localparam int unsigned CLK_HZ         = 100_000_000;
   localparam int unsigned RESET_DONE_MS  = 32;
   localparam int unsigned RESET_DONE_CYC = CLK_HZ / 1000 * RESET_DONE_MS;
   localparam int unsigned SAMPLE_SPS     = 32_000;
   localparam int unsigned SAMPLE_CYC     = CLK_HZ / SAMPLE_SPS;
   localparam logic [8:0]  DRDY_LOW_CYC   = 9'h100;
   localparam logic [3:0]  SCLK_HALF_CYC  = 4'h8;
   // Device register addresses
   localparam logic [7:0]  A_STATE0 = 8'h01;
   localparam logic [7:0]  A_STATE1 = 8'h02;
   localparam logic [7:0]  A_SETUP0 = 8'h03;
   localparam logic [7:0]  A_ALIGN  = 8'h04;
   localparam logic [7:0]  A_LOCK   = 8'h05;
   // Field positions and values
   localparam int unsigned ST0_RESET_DONE = 5;
   localparam int unsigned ST0_LINK_ALIVE = 4;
   localparam int unsigned ST0_CRC_ERR    = 0;
   localparam int unsigned SU0_FWD_EN     = 0;
   localparam int unsigned SU0_CRC_DIS    = 1;
   localparam logic [7:0]  SETUP0_RST     = 8'h00;
   localparam logic [7:0]  ALIGN_VAL      = 8'h02;
   localparam logic [7:0]  LOCK_VAL       = 8'hD4;
   // Command layout
   localparam int unsigned CMD_RD   = 31;
   localparam int unsigned CMD_LONG = 30;
   localparam int unsigned CMD_BITS = 32;
   localparam logic [7:0]  LONG_BITS = 8'h80;
   // Check codes
   localparam logic [7:0]  CRC8_POLY  = 8'h07;
   localparam logic [15:0] CRC16_POLY = 16'h1021;
   localparam logic [15:0] CRC16_INIT = 16'hFFFF;
   // Host APB map
   localparam logic [7:0]  H_CMD  = 8'h00;
   localparam logic [7:0]  H_LEN  = 8'h04;
   localparam logic [7:0]  H_STAT = 8'h08;
   localparam logic [7:0]  H_RSP0 = 8'h0C;
   localparam logic [7:0]  H_RSP3 = 8'h18;
endpackage : asu_pkg

// ===== rtl/asu_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface asu_link_if;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso_o;
   logic miso_oe;
   logic miso;
   logic ready_pin;
   // Released data-out line reads low, as through a pull-down
   assign miso = miso_oe & miso_o;
   modport dev (input sclk, input cs_n, input mosi,
                output miso_o, output miso_oe, output ready_pin);
   modport host (output sclk, output cs_n, output mosi,
                 input miso, input ready_pin);
endinterface : asu_link_if
`default_nettype wire

// ===== rtl/asu_crc8.sv
`timescale 1ns/10ps
`default_nettype none
module asu_crc8 (
   // Command fields
   input  wire logic [23:0] data,
   // Check byte
   output logic      [7:0]  crc
);
   // Bitwise MSB-first division, zero seed
   always_comb begin
      crc = 8'h00;
      for (int i = 23; i >= 0; i--) begin
         if (crc[7] ^ data[i]) begin
            crc = {crc[6:0], 1'b0} ^ asu_pkg::CRC8_POLY;
         end else begin
            crc = {crc[6:0], 1'b0};
         end
      end
   end
endmodule : asu_crc8
`default_nettype wire

// ===== rtl/asu_dev.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Reset-done bit set 32 ms after clock
// - Forward enable drives clock copy on pin
// - Forward enable clear: pin is data-ready
// - Host brings up crystal device first
// - Host-clocked systems clear forward enable everywhere
// - Align value 0x02 realigns sample timing
// - Lock value 0xD4 blocks setup writes
// - Subordinate on four-wire host-clocked bus
// - Response to previous command, command last
// - Command carries CRC8; mismatch flags error
// - Setup bit suppresses CRC error flag
// - Command selects long or short response
// - Words shifted most significant bit first
// - Host serial clock 40 kHz to 20 MHz
// - Chip select held low whole frame
// - Long response echo, samples, status layout
// - Read response data bytes and CCITT CRC
// - Write response address and readback data
// - Command bits: read, long, address, data
// - Data in sampled on rising serial clock
// - Long frame 128 bits, command last
// - New sample: alive flag, 256-cycle low pulse
module asu_dev #(
   parameter int unsigned RESET_DONE_CYC = asu_pkg::RESET_DONE_CYC
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // Serial link
   asu_link_if.dev          link,
   // Converter samples
   input  wire logic [23:0] sample_word_a,
   input  wire logic [23:0] sample_word_b,
   input  wire logic [23:0] sample_word_c,
   // Configuration view
   output logic             forward_enable,
   output logic             config_locked
);
   logic [2:0]   sync1_q;
   logic [2:0]   sync2_q;
   logic [1:0]   prev_q;
   logic [7:0]   bit_cnt_q;
   logic [31:0]  cmd_sh_q;
   logic [31:0]  prev_cmd_q;
   logic [127:0] rsp_q;
   logic         miso_q;
   logic         miso_oe_q;
   logic         pin_q;
   logic [7:0]   setup0_q;
   logic         lock_q;
   logic         crc_err_q;
   logic         alive_q;
   logic         done_q;
   logic [21:0]  done_cnt_q;
   logic [11:0]  samp_cnt_q;
   logic [8:0]   drdy_cnt_q;
   logic [23:0]  word_a_q;
   logic [23:0]  word_b_q;
   logic [23:0]  word_c_q;

   // Synchronised pin levels and edges
   wire sclk_s    = sync2_q[0];
   wire cs_s      = sync2_q[1];
   wire mosi_s    = sync2_q[2];
   wire sclk_rise = sclk_s & ~prev_q[0];
   wire sclk_fall = ~sclk_s & prev_q[0];
   wire cs_fall   = ~cs_s & prev_q[1];
   wire cs_rise   = cs_s & ~prev_q[1];

   // End-of-frame command decode
   wire [7:0] crc_calc;
   wire       frame_ok  = cs_rise && (bit_cnt_q >= 8'(asu_pkg::CMD_BITS));
   wire       crc_ok    = (crc_calc == cmd_sh_q[7:0]);
   wire       cmd_wr    = frame_ok && crc_ok && !cmd_sh_q[asu_pkg::CMD_RD];
   wire [7:0] cmd_addr  = cmd_sh_q[23:16];
   wire [7:0] cmd_data  = cmd_sh_q[15:8];
   wire       wr_setup  = cmd_wr && (cmd_addr == asu_pkg::A_SETUP0) && !lock_q;
   wire       wr_lock   = cmd_wr && (cmd_addr == asu_pkg::A_LOCK);
   wire       do_align  = cmd_wr && (cmd_addr == asu_pkg::A_ALIGN)
                          && (cmd_data == asu_pkg::ALIGN_VAL);
   wire       crc_fault = frame_ok && !crc_ok && !setup0_q[asu_pkg::SU0_CRC_DIS];
   wire       rd_state0 = frame_ok && crc_ok && cmd_sh_q[asu_pkg::CMD_RD]
                          && (cmd_addr == asu_pkg::A_STATE0);
   wire       samp_tick = done_q && (samp_cnt_q == 12'(asu_pkg::SAMPLE_CYC - 1));

   asu_crc8 u_crc8 (
      .data (cmd_sh_q[31:8]),
      .crc  (crc_calc)
   );

   // Readable register images
   logic [7:0] state0;
   logic [7:0] state1;
   always_comb begin
      state0 = 8'h00;
      state0[asu_pkg::ST0_RESET_DONE] = done_q;
      state0[asu_pkg::ST0_LINK_ALIVE] = alive_q;
      state0[asu_pkg::ST0_CRC_ERR]    = crc_err_q;
      state1 = {7'h00, lock_q};
   end

   function automatic logic [7:0] reg_rd(input logic [7:0] a);
      case (a)
         asu_pkg::A_STATE0: reg_rd = state0;
         asu_pkg::A_STATE1: reg_rd = state1;
         asu_pkg::A_SETUP0: reg_rd = setup0_q;
         default:           reg_rd = 8'h00;
      endcase
   endfunction : reg_rd

   function automatic logic [15:0] crc16(input logic [111:0] d, input int n);
      logic [15:0] c;
      c = asu_pkg::CRC16_INIT;
      for (int i = 0; i < 112; i++) begin
         if (i < n) begin
            if (c[15] ^ d[111 - i]) begin
               c = {c[14:0], 1'b0} ^ asu_pkg::CRC16_POLY;
            end else begin
               c = {c[14:0], 1'b0};
            end
         end
      end
      return c;
   endfunction : crc16

   // Response to the previous command
   wire [7:0]   p_addr  = prev_cmd_q[23:16];
   wire         p_rd    = prev_cmd_q[asu_pkg::CMD_RD];
   wire [7:0]   echo    = {prev_cmd_q[31:30], 5'h00, crc_err_q};
   wire [7:0]   byte_hi = p_rd ? reg_rd(p_addr + 8'h01) : p_addr;
   wire [7:0]   byte_lo = reg_rd(p_addr);
   wire [111:0] long_b  = {echo, word_a_q, state0, word_b_q, state1, word_c_q,
                           byte_hi, byte_lo};
   wire [31:0]  short_b = {echo, byte_hi, byte_lo, state0};
   wire [127:0] long_w  = {long_b, crc16(long_b, 112)};
   wire [127:0] short_w = {short_b, crc16({short_b, 80'h0}, 32), 80'h0};
   wire [127:0] rsp_d   = prev_cmd_q[asu_pkg::CMD_LONG] ? long_w : short_w;

   // Two-stage pin synchronisers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= 3'h3;
         sync2_q <= 3'h3;
         prev_q  <= 2'h3;
      end else begin
         sync1_q <= {link.mosi, link.cs_n, link.sclk};
         sync2_q <= sync1_q;
         prev_q  <= sync2_q[1:0];
      end
   end

   // Frame shifting: data in on rise, data out on fall
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt_q <= 8'h00;
         cmd_sh_q  <= 32'h0;
         rsp_q     <= 128'h0;
         miso_q    <= 1'b0;
         miso_oe_q <= 1'b0;
      end else begin
         miso_oe_q <= ~cs_s;
         if (cs_fall) begin
            bit_cnt_q <= 8'h00;
            rsp_q     <= rsp_d;
         end else if (!cs_s && sclk_rise) begin
            cmd_sh_q  <= {cmd_sh_q[30:0], mosi_s};
            if (bit_cnt_q != 8'hFF) begin
               bit_cnt_q <= bit_cnt_q + 8'h01;
            end
         end else if (!cs_s && sclk_fall) begin
            miso_q <= rsp_q[127];
            rsp_q  <= {rsp_q[126:0], 1'b0};
         end
      end
   end

   // Command execution at frame end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prev_cmd_q <= 32'h0;
         setup0_q   <= asu_pkg::SETUP0_RST;
         lock_q     <= 1'b0;
         crc_err_q  <= 1'b0;
      end else begin
         if (frame_ok) begin
            prev_cmd_q <= cmd_sh_q;
         end
         if (wr_setup) begin
            setup0_q <= cmd_data;
         end
         if (wr_lock) begin
            lock_q <= (cmd_data == asu_pkg::LOCK_VAL);
         end
         if (crc_fault) begin
            crc_err_q <= 1'b1;
         end else if (rd_state0) begin
            crc_err_q <= 1'b0;
         end
      end
   end

   // Reset-done timer
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         done_cnt_q <= 22'h0;
         done_q     <= 1'b0;
      end else if (!done_q) begin
         done_cnt_q <= done_cnt_q + 22'h1;
         done_q     <= (done_cnt_q == 22'(RESET_DONE_CYC - 1));
      end
   end

   // Sample timing and capture
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         samp_cnt_q <= 12'h0;
         alive_q    <= 1'b0;
         word_a_q   <= 24'h0;
         word_b_q   <= 24'h0;
         word_c_q   <= 24'h0;
      end else begin
         if (do_align || samp_tick) begin
            samp_cnt_q <= 12'h0;
         end else if (done_q) begin
            samp_cnt_q <= samp_cnt_q + 12'h1;
         end
         if (samp_tick) begin
            alive_q  <= 1'b1;
            word_a_q <= sample_word_a;
            word_b_q <= sample_word_b;
            word_c_q <= sample_word_c;
         end
      end
   end

   // Shared pin: clock copy or data-ready pulse
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         drdy_cnt_q <= 9'h0;
         pin_q      <= 1'b1;
      end else begin
         if (samp_tick) begin
            drdy_cnt_q <= asu_pkg::DRDY_LOW_CYC;
         end else if (drdy_cnt_q != 9'h0) begin
            drdy_cnt_q <= drdy_cnt_q - 9'h1;
         end
         if (setup0_q[asu_pkg::SU0_FWD_EN]) begin
            pin_q <= ~pin_q;
         end else begin
            pin_q <= ~(samp_tick || (drdy_cnt_q > 9'h1));
         end
      end
   end

   // Outputs
   assign link.miso_o    = miso_q;
   assign link.miso_oe   = miso_oe_q;
   assign link.ready_pin = pin_q;
   assign forward_enable = setup0_q[asu_pkg::SU0_FWD_EN];
   assign config_locked  = lock_q;
endmodule : asu_dev
`default_nettype wire

// ===== rtl/asu_host.sv
`timescale 1ns/10ps
`default_nettype none
module asu_host (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // APB register port
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Serial link
   asu_link_if.host         link
);
   typedef enum logic [2:0] {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_TAIL} asu_hst_e;

   asu_hst_e     st_q;
   logic [3:0]   ph_q;
   logic [7:0]   idx_q;
   logic [23:0]  cmd_q;
   logic [7:0]   len_q;
   logic [127:0] rx_q;
   logic [127:0] rsp_q;
   logic         sclk_q;
   logic         cs_q;
   logic         mosi_q;
   logic [1:0]   s1_q;
   logic [1:0]   s2_q;
   logic [31:0]  prdata_q;
   logic         pready_q;
   logic         perr_q;

   // Command word with its check byte
   wire [7:0]  crc8;
   wire [31:0] cmd_full = {cmd_q, crc8};
   asu_crc8 u_crc8 (
      .data (cmd_q),
      .crc  (crc8)
   );

   // Bus decode
   wire       acc     = psel && penable && !pready_q;
   wire       busy    = (st_q != H_IDLE);
   wire       a_rsp   = (paddr >= asu_pkg::H_RSP0) && (paddr <= asu_pkg::H_RSP3)
                        && (paddr[1:0] == 2'b00);
   wire       a_ok    = (paddr == asu_pkg::H_CMD) || (paddr == asu_pkg::H_LEN)
                        || (paddr == asu_pkg::H_STAT) || a_rsp;
   wire       wr_cmd  = acc && pwrite && (paddr == asu_pkg::H_CMD) && !busy;
   wire       wr_len  = acc && pwrite && (paddr == asu_pkg::H_LEN) && !busy;
   wire       bad     = !a_ok || (pwrite && busy) || (pwrite && a_rsp);
   wire [1:0] rsp_sel = 2'(({24'h0, paddr} - {24'h0, asu_pkg::H_RSP0}) >> 2);
   wire [31:0] rsp_w  = rsp_q[127 - 32 * rsp_sel -: 32];
   wire [31:0] rd_w   = (paddr == asu_pkg::H_CMD)  ? {cmd_q, 8'h00} :
                        (paddr == asu_pkg::H_LEN)  ? {24'h0, len_q} :
                        (paddr == asu_pkg::H_STAT) ? {30'h0, ~s2_q[1], busy} :
                        a_rsp ? rsp_w : 32'h0;

   // Bit sent at index: command occupies the last bits
   wire [7:0] rem_nx = len_q - 8'h01 - idx_q - 8'h01;
   wire [7:0] rem_0  = len_q - 8'h01;
   wire       bit_0  = (rem_0 < 8'(asu_pkg::CMD_BITS)) ? cmd_full[rem_0[4:0]] : 1'b0;
   wire       bit_nx = (rem_nx < 8'(asu_pkg::CMD_BITS)) ? cmd_full[rem_nx[4:0]] : 1'b0;
   wire       ph_end = (ph_q == asu_pkg::SCLK_HALF_CYC - 4'h1);

   // APB slave with one wait state
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pready_q <= 1'b0;
         prdata_q <= 32'h0;
         perr_q   <= 1'b0;
         cmd_q    <= 24'h0;
         len_q    <= asu_pkg::LONG_BITS;
      end else begin
         pready_q <= acc;
         perr_q   <= acc && bad;
         prdata_q <= acc ? rd_w : 32'h0;
         if (wr_cmd) begin
            cmd_q <= pwdata[31:8];
         end
         if (wr_len) begin
            len_q <= pwdata[7:0];
         end
      end
   end

   // Pin synchronisers for data out and shared pin
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= 2'h3;
         s2_q <= 2'h3;
      end else begin
         s1_q <= {link.ready_pin, link.miso};
         s2_q <= s1_q;
      end
   end

   // Frame sequencer
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_q   <= H_IDLE;
         ph_q   <= 4'h0;
         idx_q  <= 8'h0;
         sclk_q <= 1'b1;
         cs_q   <= 1'b1;
         mosi_q <= 1'b0;
         rx_q   <= 128'h0;
         rsp_q  <= 128'h0;
      end else begin
         ph_q <= ph_end ? 4'h0 : ph_q + 4'h1;
         unique case (st_q)
            H_IDLE: begin
               ph_q <= 4'h0;
               if (wr_cmd) begin
                  st_q  <= H_LEAD;
                  cs_q  <= 1'b0;
                  idx_q <= 8'h0;
               end
            end
            H_LEAD: if (ph_end) begin
               st_q   <= H_LOW;
               sclk_q <= 1'b0;
               mosi_q <= bit_0;
            end
            H_LOW: if (ph_end) begin
               st_q   <= H_HIGH;
               sclk_q <= 1'b1;
            end
            H_HIGH: if (ph_end) begin
               rx_q <= {rx_q[126:0], s2_q[0]};
               if (idx_q == len_q - 8'h01) begin
                  st_q <= H_TAIL;
               end else begin
                  st_q   <= H_LOW;
                  idx_q  <= idx_q + 8'h01;
                  sclk_q <= 1'b0;
                  mosi_q <= bit_nx;
               end
            end
            H_TAIL: if (ph_end) begin
               st_q  <= H_IDLE;
               cs_q  <= 1'b1;
               rsp_q <= rx_q;
            end
            default: st_q <= H_IDLE;
         endcase
      end
   end

   // Outputs
   assign link.sclk = sclk_q;
   assign link.cs_n = cs_q;
   assign link.mosi = mosi_q;
   assign prdata    = prdata_q;
   assign pready    = pready_q;
   assign pslverr   = perr_q;
endmodule : asu_host
`default_nettype wire

// ===== testbench/asu_link_sva.sv
`timescale 1ns/10ps
`default_nettype none
module asu_link_chk (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Link wires
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso_o,
   input wire logic miso_oe,
   input wire logic ready_pin,
   // Device configuration view
   input wire logic forward_enable,
   input wire logic config_locked
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   logic [9:0] lo_cnt_q;
   // Length of the running low stretch; all ones marks one begun in forward mode
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lo_cnt_q <= 10'h000;
      end else if (forward_enable) begin
         lo_cnt_q <= 10'h3FF;
      end else if (ready_pin) begin
         lo_cnt_q <= 10'h000;
      end else if (lo_cnt_q != 10'h3FF) begin
         lo_cnt_q <= lo_cnt_q + 10'h001;
      end
   end
   // Framing and clocking of the host end
   chk_idle_clock_high: assert property (cs_n |-> sclk)
      else $error("serial clock low while deselected");
   chk_select_lead: assert property ($fell(cs_n) |-> sclk [*7])
      else $error("serial clock moved too soon after select");
   chk_half_period: assert property ($fell(sclk) |-> !sclk [*8] ##1 sclk)
      else $error("serial clock low phase not eight cycles");
   chk_mosi_hold: assert property (!cs_n && $past(!cs_n) && sclk && $past(sclk)
      |-> $stable(mosi))
      else $error("host data moved during clock high phase");
   // Device output behaviour
   chk_miso_hold: assert property (!cs_n && !$past(cs_n, 6) && sclk && $past(sclk, 4)
      |-> $stable(miso_o))
      else $error("device data moved during clock high phase");
   chk_release_out: assert property (cs_n [*4] |-> !miso_oe)
      else $error("device drives data while deselected");
   chk_ready_width: assert property ($rose(ready_pin) && lo_cnt_q > 10'h002 && lo_cnt_q != 10'h3FF
      |-> lo_cnt_q == 10'h100)
      else $error("data ready pulse width wrong");
   chk_clock_copy: assert property (forward_enable && $past(forward_enable, 3)
      |-> ready_pin != $past(ready_pin))
      else $error("forwarded clock not toggling");
   chk_lock_holds: assert property (config_locked && $past(config_locked)
      |-> $stable(forward_enable))
      else $error("setup changed while locked");
   // Main scenarios reached
   cov_frame: cover property ($fell(cs_n));
   cov_ready: cover property ($rose(ready_pin) && lo_cnt_q == 10'h100);
   cov_forward: cover property (forward_enable && $changed(ready_pin));
endmodule : asu_link_chk
`default_nettype wire

// ===== testbench/adc_spi_subordinate_startup_test.sv
`timescale 1ns/10ps
`default_nettype none
module adc_spi_subordinate_startup_test;
   logic         mclk = 1'b0;
   logic         rst_n = 1'b0;
   logic         psel = 1'b0;
   logic         penable = 1'b0;
   logic         pwrite = 1'b0;
   logic [7:0]   paddr = 8'h00;
   logic [31:0]  pwdata = 32'h0;
   logic [31:0]  prdata;
   logic         pready;
   logic         pslverr;
   logic [23:0]  sa = 24'hA1B2C3;
   logic [23:0]  sb = 24'h5D6E7F;
   logic [23:0]  sc = 24'h123456;
   logic         fwd;
   logic         lck;
   logic [127:0] rsp;
   int           n_fail = 0;
   int           comparisons = 0;

   // Free-running system clock
   always #5 mclk = ~mclk;

   asu_link_if link ();
   asu_dev #(.RESET_DONE_CYC(50)) i_asu_dev (.mclk(mclk), .rst_n(rst_n), .link(link),
      .sample_word_a(sa), .sample_word_b(sb), .sample_word_c(sc),
      .forward_enable(fwd), .config_locked(lck));
   asu_host i_asu_host (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link));
   asu_link_chk i_asu_link_chk (.mclk(mclk), .rst_n(rst_n), .sclk(link.sclk),
      .cs_n(link.cs_n), .mosi(link.mosi), .miso_o(link.miso_o), .miso_oe(link.miso_oe),
      .ready_pin(link.ready_pin), .forward_enable(fwd), .config_locked(lck));

   // Compare and count
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   // Verdict and end of run
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_of_test

   // A bounded wait ran out
   task automatic expired();
      n_fail++;
      $display("MISMATCH %0t wait limit reached", $time);
      end_of_test();
   endtask : expired

   // One APB transfer, entered and left just after a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int k;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) expired();
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : apb

   function automatic logic [23:0] cmdw(input logic rd, input logic lng,
                                        input logic [7:0] a, input logic [7:0] d);
      return {rd, lng, 6'h00, a, d};
   endfunction : cmdw

   // Check word over the leading n response bits, first bit first
   function automatic logic [15:0] crc16(input logic [127:0] v, input int n);
      logic [15:0] c;
      c = asu_pkg::CRC16_INIT;
      for (int i = n - 1; i >= 0; i--) begin
         c = (c[15] ^ v[i]) ? {c[14:0], 1'b0} ^ asu_pkg::CRC16_POLY : {c[14:0], 1'b0};
      end
      return c;
   endfunction : crc16

   // Send one framed command and collect the response bits
   task automatic frame(input logic [23:0] cmd, input logic [7:0] len);
      logic [31:0] q;
      logic        e;
      int          k;
      apb(1'b1, asu_pkg::H_LEN, {24'h000000, len}, q, e);
      apb(1'b1, asu_pkg::H_CMD, {cmd, 8'h00}, q, e);
      k = 0;
      do begin
         apb(1'b0, asu_pkg::H_STAT, 32'h0, q, e);
         k++;
      end while (q[0] !== 1'b0 && k < 2000);
      if (q[0] !== 1'b0) expired();
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, asu_pkg::H_RSP0 + 8'(4 * i), 32'h0, q, e);
         rsp[127 - 32 * i -: 32] = q;
      end
   endtask : frame

   // Poll reset completion, then check the released data line
   task automatic t_bringup();
      int k;
      k = 0;
      do begin
         frame(cmdw(1'b1, 1'b1, asu_pkg::A_STATE0, 8'h00), 8'h80);
         k++;
      end while ((rsp[126] !== 1'b1 || rsp[88 + asu_pkg::ST0_RESET_DONE] !== 1'b1) && k < 4);
      check(32'(rsp[88 + asu_pkg::ST0_RESET_DONE]), 32'h1);
      check(32'(rsp[127:120]), 32'hC0);
      check({31'h0, link.miso_oe}, 32'h0);
   endtask : t_bringup

   // Long write answer carries address and readback
   task automatic t_write_resp();
      frame(cmdw(1'b0, 1'b1, asu_pkg::A_SETUP0, 8'h02), 8'h80);
      frame(cmdw(1'b1, 1'b1, asu_pkg::A_STATE1, 8'h00), 8'h80);
      check(32'(rsp[127:120]), 32'h40);
      check(32'(rsp[31:24]), 32'(asu_pkg::A_SETUP0));
      check(32'(rsp[23:16]), 32'h02);
      check(32'(rsp[15:0]), 32'(crc16(rsp >> 16, 112)));
      check(32'(fwd), 32'h0);
   endtask : t_write_resp

   // Clock copy on the shared pin, then back to data-ready
   task automatic t_forward();
      logic p;
      frame(cmdw(1'b0, 1'b1, asu_pkg::A_SETUP0, 8'h01), 8'h80);
      check(32'(fwd), 32'h1);
      @(posedge mclk);
      p = link.ready_pin;
      @(posedge mclk);
      check({31'h0, link.ready_pin}, {31'h0, ~p});
      frame(cmdw(1'b0, 1'b1, asu_pkg::A_SETUP0, 8'h00), 8'h80);
      check(32'(fwd), 32'h0);
   endtask : t_forward

   // Data-ready pulse width, then fresh samples in the answer
   task automatic t_ready();
      int k;
      int n;
      k = 0;
      while (link.ready_pin !== 1'b1 && k < 400) begin
         @(posedge mclk);
         k++;
      end
      while (link.ready_pin !== 1'b0 && k < 4400) begin
         @(posedge mclk);
         k++;
      end
      if (k >= 4400) expired();
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (link.ready_pin === 1'b0 && n < 1000);
      check(32'(n), 32'(asu_pkg::DRDY_LOW_CYC));
      frame(cmdw(1'b1, 1'b1, asu_pkg::A_STATE0, 8'h00), 8'h80);
      check(32'(rsp[88 + asu_pkg::ST0_LINK_ALIVE]), 32'h1);
      check(32'(rsp[119:96]), 32'(sa));
      check(32'(rsp[87:64]), 32'(sb));
      check(32'(rsp[55:32]), 32'(sc));
   endtask : t_ready

   // Short answer on a 48-clock frame
   task automatic t_short();
      frame(cmdw(1'b1, 1'b0, asu_pkg::A_STATE0, 8'h00), 8'h80);
      frame(cmdw(1'b1, 1'b1, asu_pkg::A_STATE0, 8'h00), 8'h30);
      check(32'(rsp[47:40]), 32'h80);
      check(32'(rsp[15:0]), 32'(crc16(rsp >> 16, 32)));
   endtask : t_short

   // Align restarts the sample period at frame end
   task automatic t_align();
      logic [31:0] q;
      logic        e;
      int          n;
      apb(1'b1, asu_pkg::H_LEN, 32'h00000080, q, e);
      apb(1'b1, asu_pkg::H_CMD,
          {cmdw(1'b0, 1'b1, asu_pkg::A_ALIGN, asu_pkg::ALIGN_VAL), 8'h00}, q, e);
      n = 0;
      while (link.cs_n !== 1'b1 && n < 4000) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 4000) expired();
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while ((link.ready_pin !== 1'b0 || n < 300) && n < 4000);
      if (n >= 4000) expired();
      check(32'(n >= asu_pkg::SAMPLE_CYC && n <= asu_pkg::SAMPLE_CYC + 8), 32'h1);
   endtask : t_align

   // Lock value blocks later setup writes
   task automatic t_lock();
      frame(cmdw(1'b0, 1'b1, asu_pkg::A_LOCK, asu_pkg::LOCK_VAL), 8'h80);
      check(32'(lck), 32'h1);
      frame(cmdw(1'b0, 1'b1, asu_pkg::A_SETUP0, 8'h01), 8'h80);
      frame(cmdw(1'b1, 1'b1, asu_pkg::A_STATE1, 8'h00), 8'h80);
      check(32'(fwd), 32'h0);
      check(32'(rsp[23:16]), 32'h00);
      check(32'(rsp[63:56]), 32'h01);
   endtask : t_lock

   // Reset, scenarios in order, verdict
   initial begin
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      t_bringup();
      t_write_resp();
      t_forward();
      t_ready();
      t_short();
      t_align();
      t_lock();
      end_of_test();
   end
endmodule : adc_spi_subordinate_startup_test
`default_nettype wire
